// ===== inc/clock_timer_pkg.sv
// Notes on behaviour
// - 8-bit up-counter clocked by 256 Hz tick
// - Bit 0 is 128 Hz, bit 7 is 1 Hz
// - Count read-only, zero after reset
// - Flags set on falls of 32/8/2/1 Hz bits
// - Flags set regardless of enable or priority
// - Write one clears flag, reset clears all
// - Request when flag, enable, priority above mask
// - Two-bit priority, zero disables, resets zero
// - Bits 0-3 are 1/2/8/32 Hz, enables reset off
// - Each source has its own vector address
// - Clear bit zeroes count, reads zero
// - Run bit starts, stops, keeps count
// - Run changes at tick fall, reads until stopped
package clock_timer_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int COUNT_W = 8;
	localparam int NSRC = 4;

	// Register offsets
	localparam logic [15:0] OFF_PRIO = 16'hff20;
	localparam logic [15:0] OFF_EN = 16'hff22;
	localparam logic [15:0] OFF_FLAG = 16'hff26;
	localparam logic [15:0] OFF_FLAG_CLR = 16'hff27;
	localparam logic [15:0] OFF_CTRL = 16'hff40;
	localparam logic [15:0] OFF_COUNT = 16'hff41;

	// Field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int PRIO_LO_BIT = 0;
	localparam int PRIO_HI_BIT = 1;
	localparam int FLAG_1HZ = 0;
	localparam int FLAG_2HZ = 1;
	localparam int FLAG_8HZ = 2;
	localparam int FLAG_32HZ = 3;

	// Counter bits feeding each flag
	localparam int SRC_1HZ = 7;
	localparam int SRC_2HZ = 6;
	localparam int SRC_8HZ = 4;
	localparam int SRC_32HZ = 2;

	// Values after reset
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [1:0] PRIO_RST = 2'h0;
	localparam logic [3:0] EN_RST = 4'h0;
	localparam logic [3:0] FLAG_RST = 4'h0;
	localparam logic RUN_RST = 1'b0;

	// Prescaler
	localparam int OSC_HZ = 32768;
	localparam int TICK_HZ = 256;
	localparam int OSC_DIV = OSC_HZ / TICK_HZ;
	localparam int PRESC_W = $clog2(OSC_DIV);

	// Exception vectors
	localparam logic [23:0] VEC_32HZ = 24'h000034;
	localparam logic [23:0] VEC_8HZ = 24'h000036;
	localparam logic [23:0] VEC_2HZ = 24'h000038;
	localparam logic [23:0] VEC_1HZ = 24'h00003a;
	localparam logic [23:0] VEC_NONE = 24'h000000;

	typedef enum logic {ST_STOP, ST_RUN} run_state_t;
endpackage

// ===== hdl/tick_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module tick_prescaler #(
	parameter int DIV = clock_timer_pkg::OSC_DIV,
	parameter int W = clock_timer_pkg::PRESC_W
) (
	input wire logic core_clk, // System clock
	input wire logic arst_n, // Async reset
	input wire logic osc_rise, // One pulse per oscillator cycle
	output logic tick_level_ff, // 256 Hz square wave
	output logic tick_fall_ff // Pulse on tick falling edge
);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] HALF = W'(DIV / 2 - 1);
	logic [W-1:0] div_ff;

	// free-running divider
	// Never gated by run state, so the tick phase stays stable
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff <= '0;
		end else if (osc_rise) begin
			div_ff <= (div_ff == LAST) ? '0 : div_ff + 1'b1;
		end
	end

	// Tick high in second half of each period
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_level_ff <= 1'b0;
		end else if (osc_rise && div_ff == HALF) begin
			tick_level_ff <= 1'b1;
		end else if (osc_rise && div_ff == LAST) begin
			tick_level_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_fall_ff <= 1'b0;
		end else begin
			tick_fall_ff <= osc_rise && div_ff == LAST;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/clock_timer_with_interrupts.sv
`timescale 1ns/1ns
`default_nettype none
module clock_timer_with_interrupts (
	input wire logic core_clk, // 50 MHz system clock
	input wire logic arst_n, // Async reset, active low
	input wire logic low_speed_oscillator, // 32768 Hz pin
	input wire logic [15:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire logic cpu_mask_lo, // CPU mask level bit 0
	input wire logic cpu_mask_hi, // CPU mask level bit 1
	output logic irq, // Interrupt request level
	output logic [1:0] irq_level, // Requested priority
	output logic [23:0] irq_vector, // Vector of chosen source
	output logic count_bit_128hz, // Counter bit 0
	output logic count_bit_1hz // Counter bit 7
);
	// Oscillator synchroniser
	logic osc_meta_ff;
	logic osc_sync_ff;
	logic osc_prev_ff;
	logic osc_rise;

	// Prescaler output, the square wave itself is not needed here
	logic tick_fall;

	// Counter and control state
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	logic run_req_ff;
	clock_timer_pkg::run_state_t run_state_ff;
	logic count_inc;
	logic [7:0] count_plus;
	logic count_clr;
	logic run_rd;

	// Interrupt state
	logic [1:0] prio_ff;
	logic [3:0] en_ff;
	logic [3:0] flag_ff;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [3:0] pending;
	logic [1:0] mask_level;
	logic req_now;
	logic irq_ff;
	logic [1:0] irq_level_ff;
	logic [23:0] irq_vector_ff;

	// Bus decode
	logic wr_prio;
	logic wr_en;
	logic wr_flag;
	logic wr_flag_clr;
	logic wr_ctrl;
	logic [7:0] rd_mux;
	logic [7:0] rdata_ff;

	// Gather the four source bits in flag order
	function automatic logic [3:0] pick_src(input logic [7:0] c);
		logic [3:0] s;
		s = '0;
		s[clock_timer_pkg::FLAG_1HZ] = c[clock_timer_pkg::SRC_1HZ];
		s[clock_timer_pkg::FLAG_2HZ] = c[clock_timer_pkg::SRC_2HZ];
		s[clock_timer_pkg::FLAG_8HZ] = c[clock_timer_pkg::SRC_8HZ];
		s[clock_timer_pkg::FLAG_32HZ] = c[clock_timer_pkg::SRC_32HZ];
		return s;
	endfunction

	// Four-bit register image in the low nibble, upper bits zero
	function automatic logic [7:0] pad_nibble(input logic [3:0] v);
		return {4'h0, v};
	endfunction

	// Vector of the fastest pending source, none when idle
	// Fixed order keeps the 32 Hz service latency lowest
	function automatic logic [23:0] vec_of(input logic [3:0] p);
		logic [23:0] v;
		v = clock_timer_pkg::VEC_NONE;
		if (p[clock_timer_pkg::FLAG_1HZ]) begin
			v = clock_timer_pkg::VEC_1HZ;
		end
		if (p[clock_timer_pkg::FLAG_2HZ]) begin
			v = clock_timer_pkg::VEC_2HZ;
		end
		if (p[clock_timer_pkg::FLAG_8HZ]) begin
			v = clock_timer_pkg::VEC_8HZ;
		end
		if (p[clock_timer_pkg::FLAG_32HZ]) begin
			v = clock_timer_pkg::VEC_32HZ;
		end
		return v;
	endfunction

	// Two flops before anyone looks at the pin
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_meta_ff <= 1'b0;
			osc_sync_ff <= 1'b0;
		end else begin
			osc_meta_ff <= low_speed_oscillator;
			osc_sync_ff <= osc_meta_ff;
		end
	end

	// Previous synchronised level for edge detection
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_prev_ff <= 1'b0;
		end else begin
			osc_prev_ff <= osc_sync_ff;
		end
	end

	// Edge taken after the synchroniser only
	assign osc_rise = osc_sync_ff & ~osc_prev_ff;

	// 256 Hz tick generator
	tick_prescaler #(
		.DIV(clock_timer_pkg::OSC_DIV),
		.W(clock_timer_pkg::PRESC_W)
	) u_presc (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.osc_rise(osc_rise),
		.tick_level_ff(),
		.tick_fall_ff(tick_fall)
	);

	// Write decode, one target per strobe
	always_comb begin
		wr_prio = 1'b0;
		wr_en = 1'b0;
		wr_flag = 1'b0;
		wr_flag_clr = 1'b0;
		wr_ctrl = 1'b0;
		if (wr_stb) begin
			case (addr)
				clock_timer_pkg::OFF_PRIO: begin
					wr_prio = 1'b1;
				end
				clock_timer_pkg::OFF_EN: begin
					wr_en = 1'b1;
				end
				clock_timer_pkg::OFF_FLAG: begin
					wr_flag = 1'b1;
				end
				clock_timer_pkg::OFF_FLAG_CLR: begin
					wr_flag_clr = 1'b1;
				end
				clock_timer_pkg::OFF_CTRL: begin
					wr_ctrl = 1'b1;
				end
				clock_timer_pkg::OFF_COUNT: begin
					wr_ctrl = 1'b0;
				end
				default: begin
					wr_ctrl = 1'b0;
				end
			endcase
		end
	end

	// Clear request, bit shared with the run write
	assign count_clr = wr_ctrl && wdata[clock_timer_pkg::CTRL_CLR_BIT];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_req_ff <= clock_timer_pkg::RUN_RST;
		end else if (wr_ctrl) begin
			run_req_ff <= wdata[clock_timer_pkg::CTRL_RUN_BIT];
		end
	end

	// request takes effect at tick fall
	// A stop still lets this fall increment once
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_state_ff <= clock_timer_pkg::ST_STOP;
		end else if (tick_fall) begin
			case (run_state_ff)
				clock_timer_pkg::ST_STOP: begin
					if (run_req_ff) begin
						run_state_ff <= clock_timer_pkg::ST_RUN;
					end
				end
				clock_timer_pkg::ST_RUN: begin
					if (!run_req_ff) begin
						run_state_ff <= clock_timer_pkg::ST_STOP;
					end
				end
				default: begin
					run_state_ff <= clock_timer_pkg::ST_STOP;
				end
			endcase
		end
	end

	// count on tick fall while running
	assign count_inc = tick_fall && run_state_ff == clock_timer_pkg::ST_RUN;

	// Incremented value, shared by the counter and the flag edges
	assign count_plus = count_ff + 8'h01;

	// Next count value
	always_comb begin
		nxt_count = count_ff;
		if (count_clr) begin
			nxt_count = clock_timer_pkg::COUNT_RST;
		end else if (count_inc) begin
			nxt_count = count_plus;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= clock_timer_pkg::COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// falls seen only on real increments
	// A clear is not treated as a clock edge of the bits
	assign flag_set = count_inc ? (pick_src(count_ff) & ~pick_src(count_plus)) : 4'h0;

	// write one clears, via either address
	assign flag_clr = (wr_flag || wr_flag_clr) ? wdata[3:0] : 4'h0;

	// flags set with no regard to enable
	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= clock_timer_pkg::FLAG_RST;
		end else begin
			flag_ff <= (flag_ff & ~flag_clr) | flag_set;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_ff <= clock_timer_pkg::EN_RST;
		end else if (wr_en) begin
			en_ff <= wdata[3:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prio_ff <= clock_timer_pkg::PRIO_RST;
		end else if (wr_prio) begin
			prio_ff <= {wdata[clock_timer_pkg::PRIO_HI_BIT], wdata[clock_timer_pkg::PRIO_LO_BIT]};
		end
	end

	// Enabled and latched sources
	assign pending = flag_ff & en_ff;
	assign mask_level = {cpu_mask_hi, cpu_mask_lo};

	// request while priority beats the mask
	// Level zero can never exceed any mask
	assign req_now = (|pending) && prio_ff > mask_level;

	// Request level registered for the output pin
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= req_now;
		end
	end

	// Level shown whenever a source is pending, mask or not
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_level_ff <= 2'h0;
		end else begin
			irq_level_ff <= (|pending) ? prio_ff : 2'h0;
		end
	end

	// vector of fastest pending source first
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_vector_ff <= clock_timer_pkg::VEC_NONE;
		end else begin
			irq_vector_ff <= vec_of(pending);
		end
	end

	assign run_rd = run_req_ff | (run_state_ff == clock_timer_pkg::ST_RUN);

	// Read mux, unmapped and reserved bits read zero
	always_comb begin
		rd_mux = 8'h00;
		case (addr)
			clock_timer_pkg::OFF_PRIO: begin
				rd_mux[clock_timer_pkg::PRIO_LO_BIT] = prio_ff[0];
				rd_mux[clock_timer_pkg::PRIO_HI_BIT] = prio_ff[1];
			end
			clock_timer_pkg::OFF_EN: begin
				rd_mux = pad_nibble(en_ff);
			end
			clock_timer_pkg::OFF_FLAG: begin
				rd_mux = pad_nibble(flag_ff);
			end
			clock_timer_pkg::OFF_FLAG_CLR: begin
				// Write-only alias, reads as zero
				rd_mux = 8'h00;
			end
			clock_timer_pkg::OFF_CTRL: begin
				// run bit as software sees it
				rd_mux[clock_timer_pkg::CTRL_RUN_BIT] = run_rd;
				rd_mux[clock_timer_pkg::CTRL_CLR_BIT] = 1'b0;
			end
			clock_timer_pkg::OFF_COUNT: begin
				// bit 0 fastest, bit 7 slowest
				rd_mux = count_ff;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// Read data registered, zero when no read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 8'h00;
		end else if (rd_stb) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// Outputs straight from flops
	assign rdata = rdata_ff;
	assign irq = irq_ff;
	assign irq_level = irq_level_ff;
	assign irq_vector = irq_vector_ff;
	assign count_bit_128hz = count_ff[0];
	assign count_bit_1hz = count_ff[7];
endmodule
`default_nettype wire

// ===== verif/clock_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module clock_timer_sva (
	input wire logic core_clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic [15:0] addr, // Address
	input wire logic rd_stb, // Read strobe
	input wire logic [7:0] rdata, // Read data
	input wire logic cpu_mask_lo, // Mask bit 0
	input wire logic cpu_mask_hi, // Mask bit 1
	input wire logic irq, // Request
	input wire logic [1:0] irq_level, // Level
	input wire logic [23:0] irq_vector, // Vector
	input wire logic count_bit_128hz, // Count bit 0
	input wire logic count_bit_1hz // Count bit 7
);
	logic rd_ff;
	logic [15:0] addr_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Remember the read cycle so the answer can be matched to its address
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ff <= 1'b0;
			addr_ff <= 16'h0000;
		end else begin
			rd_ff <= rd_stb;
			addr_ff <= addr;
		end
	end
	ctrl_read_a:
	assert property (rd_ff && addr_ff == clock_timer_pkg::OFF_CTRL |-> rdata[7:1] == 7'h00) else $error("ctrl pad");
	prio_read_a:
	assert property (rd_ff && addr_ff == clock_timer_pkg::OFF_PRIO |-> rdata[7:2] == 6'h00) else $error("prio pad");
	en_read_a:
	assert property (rd_ff && addr_ff == clock_timer_pkg::OFF_EN |-> rdata[7:4] == 4'h0) else $error("enable pad");
	flag_read_a:
	assert property (rd_ff && addr_ff == clock_timer_pkg::OFF_FLAG |-> rdata[7:4] == 4'h0) else $error("flag pad");
	count_read_a:
	assert property (rd_ff && addr_ff == clock_timer_pkg::OFF_COUNT |->
		rdata[0] == $past(count_bit_128hz) && rdata[7] == $past(count_bit_1hz)) else $error("count read");
	irq_mask_a:
	assert property (irq |-> irq_level > $past({cpu_mask_hi, cpu_mask_lo})) else $error("irq under mask");
	level_zero_a:
	assert property (irq_level == 2'h0 |-> !irq) else $error("irq at level 0");
	irq_vec_a:
	assert property (irq |-> irq_vector inside {24'h000034, 24'h000036, 24'h000038, 24'h00003a})
		else $error("bad vector");
	level_vec_a:
	assert property (irq_level != 2'h0 |-> irq_vector != 24'h000000) else $error("level without source");
	// Oscillator runs at one eighth of the core rate, so steps are far apart
	count_step_a:
	assert property ($rose(count_bit_128hz) |=> $stable(count_bit_128hz) [*8]) else $error("count too fast");
endmodule
bind clock_timer_with_interrupts clock_timer_sva clock_timer_sva_inst (.core_clk(core_clk), .arst_n(arst_n),
	.addr(addr), .rd_stb(rd_stb), .rdata(rdata), .cpu_mask_lo(cpu_mask_lo), .cpu_mask_hi(cpu_mask_hi), .irq(irq),
	.irq_level(irq_level), .irq_vector(irq_vector), .count_bit_128hz(count_bit_128hz), .count_bit_1hz(count_bit_1hz));
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] osc_ff = 3'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [1:0] mask = 2'h0;
	logic [7:0] rdata;
	logic irq;
	logic [1:0] irq_level;
	logic [23:0] irq_vector;
	logic bit0;
	int errors = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h000065db;
	logic bit7;
	logic [1:0] m;
	clock_timer_with_interrupts clock_timer_with_interrupts_inst (.core_clk(core_clk), .arst_n(arst_n),
		.low_speed_oscillator(osc_ff[2]), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .cpu_mask_lo(mask[0]), .cpu_mask_hi(mask[1]), .irq(irq), .irq_level(irq_level),
		.irq_vector(irq_vector), .count_bit_128hz(bit0), .count_bit_1hz(bit7));
	// Clock and a fast oscillator, still slower than the pin synchroniser needs
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) osc_ff <= osc_ff + 3'h1;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		@(negedge core_clk);
		chk(nm, e, rdata);
	endtask
	// A start waits for a tick fall before the first step, so allow two tick periods
	localparam int TICK_WAIT = 2200;
	task automatic ticks(input int n);
		logic b;
		int k;
		repeat (n) begin
			b = bit0;
			k = 0;
			while (bit0 === b && k < TICK_WAIT) begin
				@(negedge core_clk);
				k++;
			end
			if (k >= TICK_WAIT) chk("tick wait", 24'h1, 24'h0);
		end
	endtask
	task automatic ichk(input logic i, input logic [1:0] l, input logic [23:0] v);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("irq", i, irq);
		chk("irq_level", l, irq_level);
		chk("irq_vector", v, irq_vector);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Cut a hang short well past the expected span of tests
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		results();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		rchk("prio", clock_timer_pkg::OFF_PRIO, 8'h00);
		rchk("en", clock_timer_pkg::OFF_EN, 8'h00);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h00);
		rchk("ctrl", clock_timer_pkg::OFF_CTRL, 8'h00);
		$display("test reset done");
		// Random traffic, including the read-only count and a hole
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			wr(clock_timer_pkg::OFF_EN, seed[7:0]);
			wr(clock_timer_pkg::OFF_PRIO, seed[15:8]);
			wr(clock_timer_pkg::OFF_COUNT, seed[23:16]);
			wr(16'hff23, seed[31:24]);
			rchk("en", clock_timer_pkg::OFF_EN, {4'h0, seed[3:0]});
			rchk("prio", clock_timer_pkg::OFF_PRIO, {6'h00, seed[9:8]});
			rchk("count", clock_timer_pkg::OFF_COUNT, 8'h00);
			rchk("hole", 16'hff23, 8'h00);
		end
		wr(clock_timer_pkg::OFF_CTRL, 8'h02);
		rchk("ctrl", clock_timer_pkg::OFF_CTRL, 8'h00);
		$display("test registers done");
		wr(clock_timer_pkg::OFF_EN, 8'h00);
		wr(clock_timer_pkg::OFF_PRIO, 8'h00);
		wr(clock_timer_pkg::OFF_CTRL, 8'h01);
		rchk("ctrl", clock_timer_pkg::OFF_CTRL, 8'h01);
		ticks(4);
		rchk("count", clock_timer_pkg::OFF_COUNT, 8'h04);
		ticks(4);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h08);
		chk("irq", 24'h0, irq);
		// Every priority against a random mask, then the equal-level corner
		wr(clock_timer_pkg::OFF_EN, 8'h08);
		for (int p = 0; p < 4; p++) begin
			seed = xs(seed);
			m = seed[1:0];
			@(posedge core_clk);
			mask <= m;
			wr(clock_timer_pkg::OFF_PRIO, p[7:0]);
			ichk(p > m, p[1:0], clock_timer_pkg::VEC_32HZ);
		end
		@(posedge core_clk);
		mask <= 2'h3;
		ichk(1'b0, 2'h3, clock_timer_pkg::VEC_32HZ);
		@(posedge core_clk);
		mask <= 2'h0;
		wr(clock_timer_pkg::OFF_FLAG, 8'h00);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h08);
		wr(clock_timer_pkg::OFF_FLAG, 8'h08);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h00);
		ichk(1'b0, 2'h0, 24'h0);
		$display("test interrupts done");
		ticks(24);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h0c);
		wr(clock_timer_pkg::OFF_EN, 8'h0c);
		ichk(1'b1, 2'h3, clock_timer_pkg::VEC_32HZ);
		wr(clock_timer_pkg::OFF_EN, 8'h04);
		ichk(1'b1, 2'h3, clock_timer_pkg::VEC_8HZ);
		wr(clock_timer_pkg::OFF_FLAG_CLR, 8'h0c);
		rchk("flag", clock_timer_pkg::OFF_FLAG, 8'h00);
		$display("test sources done");
		// Stop waits for one more step; the bit keeps reading one until then
		ticks(1);
		wr(clock_timer_pkg::OFF_CTRL, 8'h00);
		rchk("ctrl", clock_timer_pkg::OFF_CTRL, 8'h01);
		ticks(1);
		rchk("ctrl", clock_timer_pkg::OFF_CTRL, 8'h00);
		repeat (2100) @(posedge core_clk);
		rchk("count", clock_timer_pkg::OFF_COUNT, 8'h22);
		chk("bit0", 24'h0, bit0);
		chk("bit7", 24'h0, bit7);
		wr(clock_timer_pkg::OFF_CTRL, 8'h02);
		rchk("count", clock_timer_pkg::OFF_COUNT, 8'h00);
		$display("test stop done");
		results();
	end
endmodule
`default_nettype wire
